// ==== verilog/irg_params.svh ====
// Purpose: constants of the time code generator (positions, widths, timing)
// Assumes: REF_CLK at 50 MHz
// Notes:   included by the generator; types live in irg_pkg
//
// Functional notes
// RULE1: modulated symbol is 2, 5 or 8 mark carrier periods out of ten.
// RULE2: dcls pulse lasts 2 ms for zero, 5 ms for one, 8 ms for marker.
// RULE3: frames start on the pps; carrier derives from the same disciplined clock.
// RULE4: amplitude select high in mark periods, low in space periods.
// RULE5: markers at 49, 59, 69; year units 50-53, zero 54, year tens 55-58.
// RULE6: leap-second-pending on bit 60 only in the last 59 s.
// RULE7: leap direction on bit 61, always sent as zero (add).
// RULE8: daylight-saving-pending on bit 62 only in the last 59 s.
// RULE9: daylight-saving-time on bit 63 while daylight saving is in effect.
// RULE10: offset sign bit 64, offset hours binary on 65-68, time plus offset is utc.
// RULE11: bit 70 set when the offset has an extra half hour.
// RULE12: four-bit figure of merit on 71-74, 0 locked, 0xF failed.
// RULE13: figure of merit cleared when first synchronised after power-up.
// RULE14: bit 75 is parity over all preceding bits.
// RULE15: unmodulated B002, B003, B006, B007 at 100 pps; year and sbs per variant.
// RULE16: afnor at 100 pps on 1 kHz carrier with time, date and sbs.
// RULE17: ieee1344 am 1 kHz with time, sbs and control-function extensions.
// RULE18: c37.118 like ieee1344 but offset sign bit inverted; the code sends c37 unmodulated on DCLS_OUT, not am.
// RULE19: unmodulated output active-high by default, or active-low by static input.
// RULE20: host software picks the format through the configuration input.
// RULE21: parity is even over preceding bits plus parity bit.
// RULE22: 100 symbols of 10 ms per second, reference marker on the pps edge.
`ifndef IRG_PARAMS_SVH
`define IRG_PARAMS_SVH

`define IRG_CLK_NS        20
`define IRG_MS_NS         1000000
`define IRG_MS_CYCLES     (`IRG_MS_NS / `IRG_CLK_NS)
`define IRG_SYM_MS        4'hA
`define IRG_ZERO_MS       4'h2
`define IRG_ONE_MS        4'h5
`define IRG_POS_MS        4'h8
`define IRG_FRAME_SYMS    7'h64
`define IRG_TFOM_RST      4'hF
`define IRG_TFOM_LOCK     4'h0

`define IRG_SEC_U         1
`define IRG_SEC_T         6
`define IRG_MIN_U         10
`define IRG_MIN_T         15
`define IRG_HR_U          20
`define IRG_HR_T          25
`define IRG_DAY_U         30
`define IRG_DAY_T         35
`define IRG_DAY_H         40
`define IRG_YR_U          50
`define IRG_YR_ZERO       54
`define IRG_YR_T          55
`define IRG_LSP           60
`define IRG_LS_DIR        61
`define IRG_DSP           62
`define IRG_DST           63
`define IRG_TZ_SIGN       64
`define IRG_TZ_HR         65
`define IRG_TZ_HALF       70
`define IRG_TFOM          71
`define IRG_PARITY        75
`define IRG_SBS_LO        80
`define IRG_SBS_HI        90

`endif

// ==== verilog/irg_pkg.sv ====
// Purpose: types shared by the time code generator
// Assumes: nothing
// Notes:   constants are in irg_params.svh
package irg_pkg;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_ONE  = 2'h1,
    SYM_POS  = 2'h2
  } irg_sym_t;

  typedef enum logic [2:0] {
    FMT_B002  = 3'h0,
    FMT_B003  = 3'h1,
    FMT_B006  = 3'h2,
    FMT_B007  = 3'h3,
    FMT_AFNOR = 3'h4,
    FMT_IEEE  = 3'h5,
    FMT_C37   = 3'h6
  } irg_fmt_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } irg_tx_state_t;

  // time of the second that begins at the next pps
  typedef struct packed {
    logic [6:0]  sec_bcd;
    logic [6:0]  min_bcd;
    logic [5:0]  hour_bcd;
    logic [9:0]  day_bcd;
    logic [7:0]  year_bcd;
    logic [16:0] sbs;
  } irg_time_t;

  typedef struct packed {
    logic       leap_pend;
    logic       dst_pend;
    logic       dst;
    logic       tz_neg;
    logic [3:0] tz_hours;
    logic       tz_half;
    logic [3:0] tfom;
  } irg_cf_t;

  typedef logic [199:0] irg_frame_t;

endpackage

// ==== verilog/irg_sym_buf.sv ====
// Purpose: two-entry frame buffer between composer and transmitter
// Assumes: single clock, synchronous active-low reset
// Notes:   ready is combinational from the fill count
`timescale 1ns/1ps
module irg_sym_buf #(
  parameter int W = 200
) (
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         next_wr_ptr;
  logic         next_rd_ptr;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  always_comb
  begin
    in_ready    = (count != 2'h2);
    out_valid   = (count != 2'h0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count  = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  chk_fill_bound: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    count <= 2'h2) else $error("frame buffer over two entries");

endmodule

// ==== verilog/irg_tc_gen.sv ====
// Purpose: serial time code generator, dcls and amplitude-select outputs
// Assumes: PPS is a one-cycle pulse on REF_CLK; inputs synchronous to REF_CLK
// Notes:   time and control inputs describe the second starting at the next pps
`timescale 1ns/1ps
`include "irg_params.svh"
module irg_tc_gen #(
  parameter int unsigned MS_CYCLES = `IRG_MS_CYCLES
) (
  input  wire logic             REF_CLK,
  input  wire logic             RST_N,
  input  wire logic             PPS,
  input  wire logic             SYNCED,
  input  irg_pkg::irg_fmt_t     FORMAT,
  input  wire logic             DCLS_ACT_LOW,
  input  irg_pkg::irg_time_t    TIME,
  input  irg_pkg::irg_cf_t      CF,
  output logic                  DCLS_OUT,
  output logic                  AMPL_MARK,
  output logic                  CARRIER_OUT,
  output logic                  TX_ACTIVE,
  output logic                  FRAME_DROP
);
  // ----------------------------------------------------------------
  // format decoding
  // ----------------------------------------------------------------
  function automatic logic fmt_am(irg_pkg::irg_fmt_t f);
    return (f == irg_pkg::FMT_AFNOR) || (f == irg_pkg::FMT_IEEE);
  endfunction

  function automatic logic fmt_cf(irg_pkg::irg_fmt_t f);
    return (f == irg_pkg::FMT_IEEE) || (f == irg_pkg::FMT_C37);
  endfunction

  function automatic logic fmt_year(irg_pkg::irg_fmt_t f);
    return (f == irg_pkg::FMT_B006) || (f == irg_pkg::FMT_B007) ||
           (f == irg_pkg::FMT_AFNOR) || fmt_cf(f);
  endfunction

  function automatic logic fmt_sbs(irg_pkg::irg_fmt_t f);
    return (f == irg_pkg::FMT_B003) || (f == irg_pkg::FMT_B007) ||
           (f == irg_pkg::FMT_AFNOR) || fmt_cf(f);
  endfunction

  function automatic logic [3:0] sym_ms(irg_pkg::irg_sym_t s);
    unique case (s)
      irg_pkg::SYM_ONE: return `IRG_ONE_MS;
      irg_pkg::SYM_POS: return `IRG_POS_MS;
      default:          return `IRG_ZERO_MS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // frame composition
  // ----------------------------------------------------------------
  logic [99:0]         dbits;
  logic [99:0]         pos_mask;
  irg_pkg::irg_frame_t frame;
  logic [3:0]          tfom;
  logic                seen_sync;
  logic [3:0]          next_tfom;
  logic                next_seen_sync;

  always_comb
  begin
    dbits = '0;
    dbits[`IRG_SEC_U +: 4] = TIME.sec_bcd[3:0];
    dbits[`IRG_SEC_T +: 3] = TIME.sec_bcd[6:4];
    dbits[`IRG_MIN_U +: 4] = TIME.min_bcd[3:0];
    dbits[`IRG_MIN_T +: 3] = TIME.min_bcd[6:4];
    dbits[`IRG_HR_U +: 4]  = TIME.hour_bcd[3:0];
    dbits[`IRG_HR_T +: 2]  = TIME.hour_bcd[5:4];
    dbits[`IRG_DAY_U +: 4] = TIME.day_bcd[3:0];
    dbits[`IRG_DAY_T +: 4] = TIME.day_bcd[7:4];
    dbits[`IRG_DAY_H +: 2] = TIME.day_bcd[9:8];
    if (fmt_year(FORMAT)) //RULE15
    begin
      dbits[`IRG_YR_U +: 4] = TIME.year_bcd[3:0]; //RULE5
      dbits[`IRG_YR_ZERO]   = 1'b0; //RULE5
      dbits[`IRG_YR_T +: 4] = TIME.year_bcd[7:4]; //RULE5
    end
    if (fmt_cf(FORMAT)) //RULE17
    begin
      dbits[`IRG_LSP]        = CF.leap_pend; //RULE6
      dbits[`IRG_LS_DIR]     = 1'b0; //RULE7
      dbits[`IRG_DSP]        = CF.dst_pend; //RULE8
      dbits[`IRG_DST]        = CF.dst; //RULE9
      // c37 sends the sign inverted
      dbits[`IRG_TZ_SIGN]    = CF.tz_neg ^ (FORMAT == irg_pkg::FMT_C37); //RULE10 RULE18
      dbits[`IRG_TZ_HR +: 4] = CF.tz_hours; //RULE10
      dbits[`IRG_TZ_HALF]    = CF.tz_half; //RULE11
      dbits[`IRG_TFOM +: 4]  = tfom; //RULE12
    end
    if (fmt_sbs(FORMAT)) //RULE15 RULE16
    begin
      dbits[`IRG_SBS_LO +: 9] = TIME.sbs[8:0];
      dbits[`IRG_SBS_HI +: 8] = TIME.sbs[16:9];
    end
    dbits[`IRG_PARITY] = ^dbits[`IRG_PARITY-1:0]; //RULE14 RULE21
  end

  // markers at symbol 0 and every symbol ending in 9, data in the rest
  for (genvar g = 0; g < 100; g++)
  begin : g_sym
    assign pos_mask[g] = (g == 0) || (g % 10 == 9); //RULE5 RULE22
    assign frame[2*g +: 2] = pos_mask[g] ? irg_pkg::SYM_POS :
                             (dbits[g] ? irg_pkg::SYM_ONE : irg_pkg::SYM_ZERO);
  end

  // figure of merit reads failed until the first lock, then follows input
  always_comb
  begin
    next_seen_sync = seen_sync | SYNCED;
    next_tfom      = tfom;
    if (SYNCED && !seen_sync)
    begin
      next_tfom = `IRG_TFOM_LOCK; //RULE13
    end
    else if (seen_sync)
    begin
      next_tfom = CF.tfom; //RULE12
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      seen_sync <= 1'b0;
      tfom      <= `IRG_TFOM_RST;
    end
    else
    begin
      seen_sync <= next_seen_sync;
      tfom      <= next_tfom;
    end
  end

  // ----------------------------------------------------------------
  // composer hold stage and buffer
  // ----------------------------------------------------------------
  irg_pkg::irg_frame_t hold;
  logic                hold_valid;
  irg_pkg::irg_frame_t next_hold;
  logic                next_hold_valid;
  logic                next_drop;
  logic                buf_in_ready;
  irg_pkg::irg_frame_t buf_data;
  logic                buf_valid;
  logic                buf_pop;

  // a frame stuck behind a full buffer is kept; the newer one is dropped
  always_comb
  begin
    next_hold       = hold;
    next_hold_valid = hold_valid && !buf_in_ready;
    next_drop       = 1'b0;
    if (PPS)
    begin
      if (next_hold_valid)
      begin
        next_drop = 1'b1;
      end
      else
      begin
        next_hold       = frame;
        next_hold_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      hold       <= '0;
      hold_valid <= 1'b0;
      FRAME_DROP <= 1'b0;
    end
    else
    begin
      hold       <= next_hold;
      hold_valid <= next_hold_valid;
      FRAME_DROP <= next_drop;
    end
  end

  irg_sym_buf #(.W(200)) u_buf (
    .REF_CLK   (REF_CLK),
    .RST_N     (RST_N),
    .in_data   (hold),
    .in_valid  (hold_valid),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // ----------------------------------------------------------------
  // transmitter and carrier timing
  // ----------------------------------------------------------------
  irg_pkg::irg_tx_state_t state;
  irg_pkg::irg_tx_state_t next_state;
  irg_pkg::irg_frame_t    cur;
  irg_pkg::irg_frame_t    next_cur;
  logic [15:0]            ms_cnt;
  logic [15:0]            next_ms_cnt;
  logic [3:0]             ms_idx;
  logic [3:0]             next_ms_idx;
  logic [6:0]             sym_idx;
  logic [6:0]             next_sym_idx;
  irg_pkg::irg_sym_t      cur_sym;
  logic                   ms_end;
  logic                   mark;
  logic                   next_mark;

  assign buf_pop = PPS; //RULE3
  assign cur_sym = irg_pkg::irg_sym_t'(cur[{sym_idx, 1'b0} +: 2]);
  assign ms_end  = (ms_cnt == 16'(MS_CYCLES - 1));

  always_comb
  begin
    next_state   = state;
    next_cur     = cur;
    next_sym_idx = sym_idx;
    next_ms_idx  = ms_idx;
    // carrier runs free from the disciplined clock, realigned on each pps
    next_ms_cnt  = ms_end ? 16'h0000 : ms_cnt + 16'h0001; //RULE3
    if (ms_end)
    begin
      next_ms_idx = (ms_idx == `IRG_SYM_MS - 4'h1) ? 4'h0 : ms_idx + 4'h1; //RULE22
    end
    unique case (state)
      irg_pkg::TX_IDLE: ;
      irg_pkg::TX_SEND:
      begin
        if (ms_end && ms_idx == `IRG_SYM_MS - 4'h1)
        begin
          if (sym_idx == `IRG_FRAME_SYMS - 7'h01)
          begin
            next_state = irg_pkg::TX_IDLE;
          end
          else
          begin
            next_sym_idx = sym_idx + 7'h01; //RULE22
          end
        end
      end
      default: next_state = irg_pkg::TX_IDLE;
    endcase
    if (PPS)
    begin
      next_ms_cnt  = 16'h0000; //RULE3
      next_ms_idx  = 4'h0;
      next_sym_idx = 7'h00;
      next_state   = buf_valid ? irg_pkg::TX_SEND : irg_pkg::TX_IDLE; //RULE3
      next_cur     = buf_data;
    end
    next_mark = (next_state == irg_pkg::TX_SEND) &&
                (next_ms_idx < sym_ms(irg_pkg::irg_sym_t'(next_cur[{next_sym_idx, 1'b0} +: 2])));
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state       <= irg_pkg::TX_IDLE;
      cur         <= '0;
      ms_cnt      <= 16'h0000;
      ms_idx      <= 4'h0;
      sym_idx     <= 7'h00;
      mark        <= 1'b0;
      DCLS_OUT    <= 1'b0;
      AMPL_MARK   <= 1'b0;
      CARRIER_OUT <= 1'b0;
      TX_ACTIVE   <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cur         <= next_cur;
      ms_cnt      <= next_ms_cnt;
      ms_idx      <= next_ms_idx;
      sym_idx     <= next_sym_idx;
      mark        <= next_mark; //RULE1 RULE2
      // dcls formats pulse the ttl line; am formats keep it at rest
      DCLS_OUT    <= (next_mark && !fmt_am(FORMAT)) ^ DCLS_ACT_LOW; //RULE19 RULE15
      AMPL_MARK   <= next_mark && fmt_am(FORMAT); //RULE4 RULE1
      // one carrier period per millisecond gives the 1 kHz carrier
      CARRIER_OUT <= (next_ms_cnt < 16'(MS_CYCLES / 2)); //RULE16 RULE17
      TX_ACTIVE   <= (next_state == irg_pkg::TX_SEND);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_zero_width: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE2
    (state == irg_pkg::TX_SEND && cur_sym == irg_pkg::SYM_ZERO && ms_idx >= 4'h2 && !PPS)
    |-> !mark) else $error("zero symbol too long");

  chk_one_width: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE1
    (state == irg_pkg::TX_SEND && cur_sym == irg_pkg::SYM_ONE && !PPS)
    |-> mark == (ms_idx < 4'h5)) else $error("one symbol width wrong");

  chk_pos_width: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE2
    (state == irg_pkg::TX_SEND && cur_sym == irg_pkg::SYM_POS && !PPS)
    |-> mark == (ms_idx < 4'h8)) else $error("marker width wrong");

  chk_frame_align: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE3
    (PPS && buf_valid) |=> (state == irg_pkg::TX_SEND && sym_idx == 7'h00 &&
    ms_cnt == 16'h0000 && cur_sym == irg_pkg::SYM_POS && mark))
    else $error("frame not aligned to pps");

  chk_sym_step: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE22
    (state == irg_pkg::TX_SEND && ms_end && ms_idx == 4'h9 && sym_idx < 7'h63 && !PPS)
    |=> sym_idx == $past(sym_idx) + 7'h01) else $error("symbol step wrong");

  chk_ampl_space: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE4
    !fmt_am(FORMAT) |=> !AMPL_MARK) else $error("mark amplitude on dcls format");

  chk_polarity: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE19
    !fmt_am(FORMAT) |=> DCLS_OUT == (mark ^ $past(DCLS_ACT_LOW)))
    else $error("dcls polarity wrong");

  chk_parity_even: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE21
    (^dbits[`IRG_PARITY:0]) == 1'b0) else $error("frame parity odd");

  chk_leap_dir: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE7
    dbits[`IRG_LS_DIR] == 1'b0) else $error("leap deletion sent");

  chk_tfom_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) //RULE13
    (SYNCED && !seen_sync) |=> (tfom == 4'h0 && seen_sync))
    else $error("figure of merit not cleared on first sync");

endmodule

// ==== dv/irg_rx_model.sv ====
// Purpose: far-side receiver model, measures mark length and symbol period
// Assumes: outputs of the generator sampled on REF_CLK
// Notes:   mark is either dcls active level or amplitude select high
`timescale 1ns/1ps
module irg_rx_model (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        DCLS_OUT,
  input  wire logic        DCLS_ACT_LOW,
  input  wire logic        AMPL_MARK,
  input  wire logic        TX_ACTIVE,
  output logic             sym_vld,
  output logic [15:0]      sym_len,
  output logic [15:0]      sym_per
);
  logic        mark;
  logic        mark_d;
  logic        first;
  logic [15:0] cnt;
  logic [15:0] pcnt;

  // polarity is undone here so both dcls senses decode alike
  assign mark = TX_ACTIVE & ((DCLS_OUT ^ DCLS_ACT_LOW) | AMPL_MARK);

  always @(posedge REF_CLK)
  begin
    sym_vld <= 1'b0;
    if (!RST_N || !TX_ACTIVE)
    begin
      cnt    <= 16'h0;
      pcnt   <= 16'h0;
      first  <= 1'b1;
      mark_d <= 1'b0;
    end
    else
    begin
      mark_d <= mark;
      pcnt   <= pcnt + 16'h1;
      if (mark)
        cnt <= cnt + 16'h1;
      if (mark && !mark_d)
      begin
        sym_per <= first ? 16'h0 : pcnt;
        pcnt    <= 16'h1;
        cnt     <= 16'h1;
        first   <= 1'b0;
      end
      if (!mark && mark_d)
      begin
        sym_vld <= 1'b1;
        sym_len <= cnt;
      end
    end
  end
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the time code generator
// Assumes: MS_CYCLES shortened to 10, so a frame is 10000 cycles
// Notes:   expected mark lengths are queued at each pps after the first and popped per symbol
`timescale 1ns/1ps
module tb;
  localparam int unsigned MS    = 10;
  localparam int          LIMIT = 95000;

  logic                 REF_CLK;
  logic                 RST_N;
  logic                 PPS;
  logic                 SYNCED;
  irg_pkg::irg_fmt_t    FORMAT;
  logic                 DCLS_ACT_LOW;
  irg_pkg::irg_time_t   TIME;
  irg_pkg::irg_cf_t     CF;
  logic                 DCLS_OUT, AMPL_MARK, CARRIER_OUT, TX_ACTIVE, FRAME_DROP;
  logic                 sym_vld;
  logic [15:0]          sym_len, sym_per, exp_len;
  logic [15:0]          exp_q[$];
  int                   num_errors, samples_checked, cyc;

  irg_tc_gen #(.MS_CYCLES(MS)) dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PPS(PPS),
    .SYNCED(SYNCED), .FORMAT(FORMAT), .DCLS_ACT_LOW(DCLS_ACT_LOW), .TIME(TIME), .CF(CF),
    .DCLS_OUT(DCLS_OUT), .AMPL_MARK(AMPL_MARK), .CARRIER_OUT(CARRIER_OUT),
    .TX_ACTIVE(TX_ACTIVE), .FRAME_DROP(FRAME_DROP));

  irg_rx_model rx_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .DCLS_OUT(DCLS_OUT),
    .DCLS_ACT_LOW(DCLS_ACT_LOW), .AMPL_MARK(AMPL_MARK), .TX_ACTIVE(TX_ACTIVE),
    .sym_vld(sym_vld), .sym_len(sym_len), .sym_per(sym_per));

  initial REF_CLK = 1'b0;
  always #10 REF_CLK = ~REF_CLK;

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic miss(input string msg);
    num_errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
      miss($sformatf("bit got %b exp %b", got, exp));
  endtask

  task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
      miss($sformatf("cycles got %0d exp %0d", got, exp));
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // frame content as the receiver should decode it, markers left as zero
  function automatic logic [99:0] exp_frame(input irg_pkg::irg_fmt_t f,
    input irg_pkg::irg_time_t t, input irg_pkg::irg_cf_t c, input logic [3:0] fom);
    logic [99:0] b;
    b = '0;
    b[8:1]   = {t.sec_bcd[6:4], 1'b0, t.sec_bcd[3:0]};
    b[17:10] = {t.min_bcd[6:4], 1'b0, t.min_bcd[3:0]};
    b[26:20] = {t.hour_bcd[5:4], 1'b0, t.hour_bcd[3:0]};
    b[41:30] = {t.day_bcd[9:8], 1'b0, t.day_bcd[7:4], 1'b0, t.day_bcd[3:0]};
    if (f >= irg_pkg::FMT_B006)
      b[58:50] = {t.year_bcd[7:4], 1'b0, t.year_bcd[3:0]};
    if (f == irg_pkg::FMT_IEEE || f == irg_pkg::FMT_C37)
    begin
      b[63:60] = {c.dst, c.dst_pend, 1'b0, c.leap_pend};
      b[68:64] = {c.tz_hours, c.tz_neg ^ (f == irg_pkg::FMT_C37)};
      b[74:70] = {fom, c.tz_half};
    end
    b[75] = ^b[74:0];
    if (f != irg_pkg::FMT_B002 && f != irg_pkg::FMT_B006)
      b[97:80] = {t.sbs[16:9], 1'b0, t.sbs[8:0]};
    return b;
  endfunction

  task automatic pps_step(input logic busy);
    @(posedge REF_CLK);
    #1 PPS = 1'b1;
    @(posedge REF_CLK);
    #1 PPS = 1'b0;
    chk_bit(TX_ACTIVE, busy);
    // the buffer drains at every pps, so no frame may ever be discarded
    chk_bit(FRAME_DROP, 1'b0);
    if (busy)
    begin
      chk_bit((DCLS_OUT ^ DCLS_ACT_LOW) | AMPL_MARK, 1'b1);
      chk_bit(CARRIER_OUT, 1'b1);
    end
    // carrier realigned at the pps must fall half a millisecond later
    repeat (MS / 2) @(posedge REF_CLK);
    #1 chk_bit(CARRIER_OUT, 1'b0);
  endtask

  // ----------------------------------------
  // symbol watcher and timeout
  // ----------------------------------------
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      miss("timeout");
      end_sim;
    end
    if (sym_vld === 1'b1)
    begin
      if (exp_q.size() == 0)
        miss("symbol without expectation");
      else
      begin
        exp_len = exp_q.pop_front();
        chk_len(sym_len, exp_len);
      end
      if (sym_per !== 16'h0)
        chk_len(sym_per, 16'(10 * MS));
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    irg_pkg::irg_fmt_t fmts[7];
    logic [99:0]       bits;
    logic [3:0]        fom;
    logic [63:0]       r;
    int                i;
    int                g;
    int                n;
    fmts = '{irg_pkg::FMT_B002, irg_pkg::FMT_B003, irg_pkg::FMT_B006, irg_pkg::FMT_B007,
             irg_pkg::FMT_IEEE, irg_pkg::FMT_C37, irg_pkg::FMT_AFNOR};
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    bits = '0;
    RST_N = 1'b0;
    PPS = 1'b0;
    SYNCED = 1'b0;
    FORMAT = irg_pkg::FMT_B002;
    DCLS_ACT_LOW = 1'b0;
    TIME = '0;
    CF = '0;
    r[31:0] = $urandom(32'hAF8EDEB4);
    repeat (20) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      // polarity only moves while idle, it is a static strap
      DCLS_ACT_LOW = (i >= 5);
      if (i < 7)
      begin
        r = {$urandom(), $urandom()};
        FORMAT = fmts[i];
        TIME = r[$bits(irg_pkg::irg_time_t)-1:0];
        CF = r[63 -: $bits(irg_pkg::irg_cf_t)];
      end
      repeat (20) @(posedge REF_CLK);
      #1 chk_bit(DCLS_OUT, DCLS_ACT_LOW);
      pps_step(i > 0);
      if (i > 0)
        for (g = 0; g < 100; g++)
        begin
          n = (g == 0 || g % 10 == 9) ? 8 : (bits[g] ? 5 : 2);
          exp_q.push_back(16'(MS * n));
        end
      fom = (i >= 5) ? CF.tfom : 4'hF;
      bits = exp_frame(FORMAT, TIME, CF, fom);
      if (i == 4)
        SYNCED = 1'b1;
      repeat (100 * 10 * MS + 30) @(posedge REF_CLK);
      #1 chk_bit(TX_ACTIVE, 1'b0);
    end
    chk_len(16'(exp_q.size()), 16'h0);
    end_sim;
  end
endmodule
